// File: gpfs_pkg.sv
// package: constants, types and register map for the general pin function select block
package gpfs_pkg;

  // ==========================================================================
  // register map (byte addresses on ahb-lite)
  // ==========================================================================
  localparam logic [7:0] CTRL_OFS = 8'h00; // bit0 alter designation flag, bit1 apply strobe
  localparam logic [7:0] PIN_B_OFS = 8'h04;
  localparam logic [7:0] PIN_C_OFS = 8'h08;
  localparam logic [7:0] PIN_D_OFS = 8'h0C;
  localparam logic [7:0] STAT_OFS = 8'h10; // synced levels of pins b, c and d in bits 0 to 2

  // ==========================================================================
  // settings byte layout
  // ==========================================================================
  localparam int DESIG_LSB = 0;
  localparam int DIR_BIT = 3;
  localparam int VAL_BIT = 4;
  localparam int ALTER_BIT = 0;
  localparam int APPLY_BIT = 1;
  localparam logic [7:0] SETTING_RST = 8'h08; // gpio input after reset

  // ==========================================================================
  // designation codes
  // ==========================================================================
  localparam logic [2:0] DES_GPIO = 3'h0;
  localparam logic [2:0] DES_DED = 3'h1;
  localparam logic [2:0] DES_ALT0 = 3'h2;
  localparam logic [2:0] DES_ALT1 = 3'h3;
  localparam logic [2:0] DES_ALT2 = 3'h4;

  // per pin selected function after decode
  typedef enum logic [2:0] {
    GPFS_FN_GPIO = 3'b000,
    GPFS_FN_DED = 3'b001,
    GPFS_FN_ALT0 = 3'b010,
    GPFS_FN_ALT1 = 3'b011,
    GPFS_FN_ALT2 = 3'b100,
    GPFS_FN_NONE = 3'b111
  } gpfs_fn_t;

  // pad drive bundle
  typedef struct packed {
    logic out;
    logic oe;
  } gpfs_pad_t;

  // ahb address phase capture
  typedef struct packed {
    logic valid;
    logic write;
    logic [7:0] addr;
  } gpfs_aphase_t;

endpackage

// File: gpfs_sync.sv
// three flop pin synchroniser that updates once flops two and three agree
module gpfs_sync (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic pin_in,
  output logic pin_sync
);
  logic [2:0] stage;
  logic [2:0] next_stage;
  logic next_pin_sync;

  // ==========================================================================
  // shift and agree
  // ==========================================================================
  always_comb begin
    next_stage = {stage[1:0], pin_in};
    next_pin_sync = (stage[2] == stage[1]) ? stage[2] : pin_sync;
  end

  // flop one feeds flop two only
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      stage <= 3'h0;
      pin_sync <= 1'b0;
    end else begin
      stage <= next_stage;
      pin_sync <= next_pin_sync;
    end
  end
endmodule // gpfs_sync

// File: gpfs_pin_route.sv
// one general pin: decodes its settings byte and chooses the pad drive
module gpfs_pin_route #(
  parameter logic [2:0] MAX_CODE = 3'h3
) (
  input wire logic [7:0] setting,
  input wire logic fn_ded,
  input wire logic fn_alt1,
  input wire logic fn_alt2_in,
  output gpfs_pkg::gpfs_fn_t fn,
  output gpfs_pkg::gpfs_pad_t pad
);
  logic [2:0] code;
  assign code = setting[gpfs_pkg::DESIG_LSB +: 3];

  // ==========================================================================
  // decode and drive
  // ==========================================================================
  // codes above the pin's last one are left undriven as inputs
  always_comb begin
    fn = gpfs_pkg::GPFS_FN_NONE;
    pad = '0;
    if (code <= MAX_CODE) begin
      fn = gpfs_pkg::gpfs_fn_t'(code);
    end
    unique case (fn)
      gpfs_pkg::GPFS_FN_GPIO: begin
        pad.oe = ~setting[gpfs_pkg::DIR_BIT];
        pad.out = setting[gpfs_pkg::VAL_BIT];
      end
      gpfs_pkg::GPFS_FN_DED: begin
        pad.oe = 1'b1;
        pad.out = fn_ded;
      end
      gpfs_pkg::GPFS_FN_ALT1: begin
        pad.oe = 1'b1;
        pad.out = fn_alt1;
      end
      // analog and edge detect inputs keep the digital driver off
      gpfs_pkg::GPFS_FN_ALT0, gpfs_pkg::GPFS_FN_ALT2, gpfs_pkg::GPFS_FN_NONE: begin
        pad.oe = 1'b0;
        pad.out = fn_alt2_in & 1'b0;
      end
    endcase
  end
endmodule // gpfs_pin_route

// File: gpfs_top.sv
// top of the general pin function select block with its ahb-lite register slave
// Notes on behaviour
// - pin b code 000 gpio, 001 clock out, 010 analog in one, 011 tx activity, 100 edge detect.
// - pin c code 000 gpio, 001 usb configured indicator, 010 analog in two, 011 analog out one.
// - pin d code 000 gpio, 001 i2c activity, 010 analog in three, 011 analog out two.
// - a pin in gpio output mode drives the level of bit 4 of its settings byte.
// - bit 3 set makes a gpio pin an input, clear makes it an output, only in gpio mode.
// - pin d uses the same byte layout with bit 4 as its output level.
// - new settings load only when the alter designation flag is one on an apply.
module gpfs_top (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic clock_out_src,
  input wire logic serial_tx_activity_indicator,
  input wire logic usb_configured_indicator,
  input wire logic i2c_activity_indicator,
  input wire logic general_pin_b_in,
  output logic general_pin_b_out,
  output logic general_pin_b_oe,
  input wire logic general_pin_c_in,
  output logic general_pin_c_out,
  output logic general_pin_c_oe,
  input wire logic general_pin_d_in,
  output logic general_pin_d_out,
  output logic general_pin_d_oe,
  output logic analog_input_one,
  output logic analog_input_two,
  output logic analog_input_three,
  output logic analog_output_one,
  output logic analog_output_two,
  output logic edge_detect_en,
  output logic edge_detect_level
);

  // ==========================================================================
  // ahb-lite slave: zero wait states, always okay
  // ==========================================================================
  gpfs_pkg::gpfs_aphase_t aph;
  gpfs_pkg::gpfs_aphase_t next_aph;
  // staged bytes are what software last wrote; active bytes drive the pins
  logic [7:0] stage_b;
  logic [7:0] stage_c;
  logic [7:0] stage_d;
  logic [7:0] next_stage_b;
  logic [7:0] next_stage_c;
  logic [7:0] next_stage_d;
  logic [7:0] set_b;
  logic [7:0] set_c;
  logic [7:0] set_d;
  logic [7:0] next_set_b;
  logic [7:0] next_set_c;
  logic [7:0] next_set_d;
  logic alter_flag;
  logic next_alter_flag;
  logic [31:0] next_hrdata;
  logic sync_b;
  logic sync_c;
  logic sync_d;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [7:0] sb,
      input logic [7:0] sc, input logic [7:0] sd, input logic alt, input logic [7:0] stat);
    unique case (a)
      gpfs_pkg::CTRL_OFS: rd_mux = {31'h0, alt};
      gpfs_pkg::PIN_B_OFS: rd_mux = {24'h0, sb};
      gpfs_pkg::PIN_C_OFS: rd_mux = {24'h0, sc};
      gpfs_pkg::PIN_D_OFS: rd_mux = {24'h0, sd};
      gpfs_pkg::STAT_OFS: rd_mux = {24'h0, stat};
      default: rd_mux = 32'h0;
    endcase
  endfunction

  logic apply;
  logic [7:0] status;
  assign status = {5'h0, sync_d, sync_c, sync_b};

  // address phase capture, staging writes, reads answered from the registered data
  always_comb begin
    next_aph.valid = hsel & hready & htrans[1];
    next_aph.write = hwrite;
    next_aph.addr = haddr[7:0];
    next_stage_b = stage_b;
    next_stage_c = stage_c;
    next_stage_d = stage_d;
    next_alter_flag = alter_flag;
    apply = 1'b0;
    next_hrdata = hrdata;
    if (aph.valid & aph.write) begin
      unique case (aph.addr)
        gpfs_pkg::CTRL_OFS: begin
          next_alter_flag = hwdata[gpfs_pkg::ALTER_BIT];
          apply = hwdata[gpfs_pkg::APPLY_BIT];
        end
        gpfs_pkg::PIN_B_OFS: next_stage_b = hwdata[7:0];
        gpfs_pkg::PIN_C_OFS: next_stage_c = hwdata[7:0];
        gpfs_pkg::PIN_D_OFS: next_stage_d = hwdata[7:0];
        default: next_alter_flag = alter_flag; // unmapped: ignored, okay
      endcase
    end
    // read from the next values so a read right behind a write sees the new data
    if (hsel & hready & htrans[1] & ~hwrite) begin
      next_hrdata = rd_mux(haddr[7:0], next_stage_b, next_stage_c, next_stage_d,
        next_alter_flag, status);
    end
  end

  // active settings follow staging only on apply with alter flag set
  always_comb begin
    next_set_b = set_b;
    next_set_c = set_c;
    next_set_d = set_d;
    if (apply && hwdata[gpfs_pkg::ALTER_BIT]) begin
      next_set_b = stage_b;
      next_set_c = stage_c;
      next_set_d = stage_d;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      aph <= '0;
      stage_b <= gpfs_pkg::SETTING_RST;
      stage_c <= gpfs_pkg::SETTING_RST;
      stage_d <= gpfs_pkg::SETTING_RST;
      set_b <= gpfs_pkg::SETTING_RST;
      set_c <= gpfs_pkg::SETTING_RST;
      set_d <= gpfs_pkg::SETTING_RST;
      alter_flag <= 1'b0;
      hrdata <= 32'h0;
    end else begin
      aph <= next_aph;
      stage_b <= next_stage_b;
      stage_c <= next_stage_c;
      stage_d <= next_stage_d;
      set_b <= next_set_b;
      set_c <= next_set_c;
      set_d <= next_set_d;
      alter_flag <= next_alter_flag;
      hrdata <= next_hrdata;
    end
  end

  // never stalls: every register answers from flops in the data phase
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ==========================================================================
  // pin inputs and routing
  // ==========================================================================
  gpfs_sync u_sync_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(general_pin_b_in),
    .pin_sync(sync_b)
  );
  gpfs_sync u_sync_c (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(general_pin_c_in),
    .pin_sync(sync_c)
  );
  gpfs_sync u_sync_d (
    .hclk(hclk),
    .hresetn(hresetn),
    .pin_in(general_pin_d_in),
    .pin_sync(sync_d)
  );

  gpfs_pkg::gpfs_fn_t fn_b, fn_c, fn_d;
  gpfs_pkg::gpfs_pad_t pad_b, pad_c, pad_d;
  logic next_analog_input_one;
  logic next_analog_input_two;
  logic next_analog_input_three;
  logic next_analog_output_one;
  logic next_analog_output_two;
  logic next_edge_detect_en;
  logic next_edge_detect_level;

  // function flags follow the decoded designation of the active bytes
  always_comb begin
    next_analog_input_one = (fn_b == gpfs_pkg::GPFS_FN_ALT0);
    next_analog_input_two = (fn_c == gpfs_pkg::GPFS_FN_ALT0);
    next_analog_input_three = (fn_d == gpfs_pkg::GPFS_FN_ALT0);
    next_analog_output_one = (fn_c == gpfs_pkg::GPFS_FN_ALT1);
    next_analog_output_two = (fn_d == gpfs_pkg::GPFS_FN_ALT1);
    next_edge_detect_en = (fn_b == gpfs_pkg::GPFS_FN_ALT2);
    next_edge_detect_level = sync_b;
  end

  // direction and level bits only matter in gpio mode
  gpfs_pin_route #(.MAX_CODE(gpfs_pkg::DES_ALT2)) u_route_b (
    .setting(set_b),
    .fn_ded(clock_out_src),
    .fn_alt1(serial_tx_activity_indicator),
    .fn_alt2_in(sync_b),
    .fn(fn_b),
    .pad(pad_b)
  );
  gpfs_pin_route #(.MAX_CODE(gpfs_pkg::DES_ALT1)) u_route_c (
    .setting(set_c),
    .fn_ded(usb_configured_indicator),
    .fn_alt1(1'b0),
    .fn_alt2_in(1'b0),
    .fn(fn_c),
    .pad(pad_c)
  );
  gpfs_pin_route #(.MAX_CODE(gpfs_pkg::DES_ALT1)) u_route_d (
    .setting(set_d),
    .fn_ded(i2c_activity_indicator),
    .fn_alt1(1'b0),
    .fn_alt2_in(1'b0),
    .fn(fn_d),
    .pad(pad_d)
  );

  // all pad and analog controls are registered; one cycle after the settings update
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      general_pin_b_out <= 1'b0;
      general_pin_b_oe <= 1'b0;
      general_pin_c_out <= 1'b0;
      general_pin_c_oe <= 1'b0;
      general_pin_d_out <= 1'b0;
      general_pin_d_oe <= 1'b0;
      analog_input_one <= 1'b0;
      analog_input_two <= 1'b0;
      analog_input_three <= 1'b0;
      analog_output_one <= 1'b0;
      analog_output_two <= 1'b0;
      edge_detect_en <= 1'b0;
      edge_detect_level <= 1'b0;
    end else begin
      general_pin_b_out <= pad_b.out;
      general_pin_b_oe <= pad_b.oe;
      general_pin_c_out <= pad_c.out;
      general_pin_c_oe <= pad_c.oe;
      general_pin_d_out <= pad_d.out;
      general_pin_d_oe <= pad_d.oe;
      analog_input_one <= next_analog_input_one;
      analog_input_two <= next_analog_input_two;
      analog_input_three <= next_analog_input_three;
      analog_output_one <= next_analog_output_one;
      analog_output_two <= next_analog_output_two;
      edge_detect_en <= next_edge_detect_en;
      edge_detect_level <= next_edge_detect_level;
    end
  end

  // ==========================================================================
  // checks
  // ==========================================================================
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  gpio_out_level_a: assert property ((set_b[2:0] == 3'h0 && !set_b[3]) |=>
    (general_pin_b_oe && general_pin_b_out == $past(set_b[4])))
    else $error("pin b gpio output level wrong");
  gpio_in_dir_a: assert property ((set_c[2:0] == 3'h0 && set_c[3]) |=> !general_pin_c_oe)
    else $error("pin c gpio input still driven");
  pin_d_level_a: assert property ((set_d[2:0] == 3'h0 && !set_d[3]) |=>
    (general_pin_d_out == $past(set_d[4])))
    else $error("pin d output level wrong");
  hold_no_alter_a: assert property ((apply && !hwdata[0]) |=> $stable(set_b))
    else $error("settings changed without alter flag");
  load_alter_a: assert property ((apply && hwdata[0]) |=> (set_c == $past(stage_c)))
    else $error("settings not loaded on alter");
  clk_route_a: assert property ((set_b[2:0] == 3'h1) |=>
    (general_pin_b_oe && general_pin_b_out == $past(clock_out_src)))
    else $error("pin b clock route wrong");
  edge_route_a: assert property ((set_b[2:0] == 3'h4) |=>
    (edge_detect_en && !general_pin_b_oe))
    else $error("pin b edge detect route wrong");
  dac_route_a: assert property ((set_c[2:0] == 3'h3) |=>
    (analog_output_one && !analog_input_two))
    else $error("pin c analog out route wrong");
  tx_route_a: assert property ((set_b[2:0] == gpfs_pkg::DES_ALT1) |=>
    (general_pin_b_oe && general_pin_b_out == $past(serial_tx_activity_indicator)))
    else $error("pin b tx activity route wrong");
  usb_route_a: assert property ((set_c[2:0] == gpfs_pkg::DES_DED) |=>
    (general_pin_c_oe && general_pin_c_out == $past(usb_configured_indicator)))
    else $error("pin c usb indicator route wrong");
  undef_idle_a: assert property ((set_d[2:0] > gpfs_pkg::DES_ALT1) |=>
    (!general_pin_d_oe && !analog_output_two))
    else $error("pin d undefined code still active");
  i2c_route_a: assert property ((set_d[2:0] == 3'h1) |=>
    (general_pin_d_out == $past(i2c_activity_indicator)))
    else $error("pin d i2c indicator route wrong");

  apply_c: cover property (apply && hwdata[0]);
  gpio_out_c: cover property (general_pin_b_oe && set_b[2:0] == 3'h0);
  adc_c: cover property (analog_input_three);
  hold_c: cover property (apply && !hwdata[gpfs_pkg::ALTER_BIT]);
endmodule // gpfs_top

// File: gpfs_pad_model.sv
// board side of the three general pins: pad drive when enabled, else an external level
module gpfs_pad_model (
  input wire logic [2:0] pad_oe,
  input wire logic [2:0] pad_out,
  input wire logic [2:0] ext_level,
  output logic [2:0] pin_level
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // pin resolution
  // ==========================================================================
  // the board always drives a released pin, so the synced level is never left floating
  always_comb begin
    for (int p = 0; p < 3; p++) begin
      pin_level[p] = pad_oe[p] ? pad_out[p] : ext_level[p];
    end
  end
endmodule // gpfs_pad_model

// File: gpfs_top_tb.sv
// self-checking testbench for the general pin function select block
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module gpfs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, alt, edl;
  logic [1:0] htrans;
  logic [2:0] hsize, oe_w, out_w, pin_w, ext;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] src; // clock, tx activity, usb configured, i2c activity
  logic [5:0] aflags;
  logic [7:0] act [3];
  logic [7:0] stg [3];
  logic [15:0] seed;
  int err_total = 0;
  int n_tests = 0;
  int cyc = 0;
  gpfs_top i_gpfs_top (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .clock_out_src(src[0]),
    .serial_tx_activity_indicator(src[1]), .usb_configured_indicator(src[2]),
    .i2c_activity_indicator(src[3]), .general_pin_b_in(pin_w[0]),
    .general_pin_b_out(out_w[0]), .general_pin_b_oe(oe_w[0]), .general_pin_c_in(pin_w[1]),
    .general_pin_c_out(out_w[1]), .general_pin_c_oe(oe_w[1]), .general_pin_d_in(pin_w[2]),
    .general_pin_d_out(out_w[2]), .general_pin_d_oe(oe_w[2]),
    .analog_input_one(aflags[5]), .analog_input_two(aflags[4]),
    .analog_input_three(aflags[3]), .analog_output_one(aflags[2]),
    .analog_output_two(aflags[1]), .edge_detect_en(aflags[0]), .edge_detect_level(edl)
  );
  gpfs_pad_model i_gpfs_pad_model (
    .pad_oe(oe_w), .pad_out(out_w), .ext_level(ext), .pin_level(pin_w)
  );
  // ==========================================================================
  // clock, timeout and verdict
  // ==========================================================================
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // a hung bus wait ends here instead of running forever
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_total++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ==========================================================================
  // helpers
  // ==========================================================================
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  // single word transfer; waits on hready rather than assuming zero wait states
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
    `CHK("bus response", 1'b0, hresp)
  endtask
  // {oe checked, oe, level}; analog output pins (code 011 on pins c and d) leave the pad enable unchecked
  function automatic logic [2:0] exp_pad(input int p, input logic [7:0] s);
    case (s[2:0])
      3'h0: return {1'b1, ~s[3], s[4]};
      3'h1: return {2'h3, src[(p == 0) ? 0 : p + 1]};
      3'h3: return (p == 0) ? {2'h3, src[1]} : 3'h0;
      default: return 3'h4;
    endcase
  endfunction
  task automatic check_pins();
    logic [2:0] e;
    for (int p = 0; p < 3; p++) begin
      e = exp_pad(p, act[p]);
      if (e[2]) `CHK("pad enable", e[1], oe_w[p])
      if (e[2] && e[1]) `CHK("pad level", e[0], out_w[p])
    end
    `CHK("function flags", {act[0][2:0] == 3'h2, act[1][2:0] == 3'h2, act[2][2:0] == 3'h2,
      act[1][2:0] == 3'h3, act[2][2:0] == 3'h3, act[0][2:0] == 3'h4}, aflags)
  endtask
  // ==========================================================================
  // main sequence
  // ==========================================================================
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    src = 4'h0;
    ext = 3'h5;
    seed = 16'h74CA;
    for (int p = 0; p < 3; p++) act[p] = gpfs_pkg::SETTING_RST;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    #1 check_pins();
    // reset values, an unmapped write that must vanish, and synced pin levels
    for (int a = 0; a < 4; a++) begin
      ahb(1'b0, 8'(4 * a), 32'h0);
      `CHK("reset value", (a == 0) ? 32'h0 : 32'h8, rd)
    end
    ahb(1'b1, 8'h20, 32'hFFFFFFFF);
    ahb(1'b0, 8'h20, 32'h0);
    `CHK("unmapped read", 32'h0, rd)
    repeat (6) @(posedge hclk);
    ahb(1'b0, gpfs_pkg::STAT_OFS, 32'h0);
    `CHK("pin status", ext, rd[2:0])
    `CHK("edge level", ext[0], edl)
    // first eight passes sweep every code on all pins, then random settings
    for (int i = 0; i < 48; i++) begin
      for (int p = 0; p < 3; p++) begin
        seed = lfsr(seed);
        stg[p] = (i < 8) ? {3'h0, i[0], 1'b0, i[2:0]} : seed[7:0];
        ahb(1'b1, gpfs_pkg::PIN_B_OFS + 8'(4 * p), {24'h0, stg[p]});
      end
      alt = (i < 8) || (i % 4 != 3);
      src <= seed[11:8];
      ext <= seed[14:12];
      ahb(1'b1, gpfs_pkg::CTRL_OFS, {30'h0, 1'b1, alt});
      if (alt) act = stg;
      repeat (2) @(posedge hclk);
      #1 check_pins();
      src <= ~src;
      repeat (2) @(posedge hclk);
      #1 check_pins();
      ahb(1'b0, gpfs_pkg::CTRL_OFS, 32'h0);
      `CHK("alter flag", alt, rd[0])
      // pins settled several cycles ago, so the synced view must match the board
      ahb(1'b0, gpfs_pkg::STAT_OFS, 32'h0);
      `CHK("pin status", pin_w, rd[2:0])
      `CHK("edge level", pin_w[0], edl)
    end
    report_and_stop();
  end
endmodule // gpfs_top_tb
